// ---- inc/fbsa_defines.svh ----
/*
  constants of the four-bit slice: instruction field positions, register offsets,
  reset values and bus response codes.
  assumes it is included by its bare name from the axil and slice modules.
*/
`ifndef FBSA_DEFINES_SVH
`define FBSA_DEFINES_SVH

`define FBSA_SRC_LSB      4'd0
`define FBSA_FUNC_LSB     4'd3
`define FBSA_DEST_LSB     4'd6

`define FBSA_CTRL_OFS     4'h0
`define FBSA_STAT_OFS     4'h4
`define FBSA_CTRL_RST     32'h00000001
`define FBSA_CTRL_RUN_BIT 0

`define FBSA_STAT_AUX_LSB 0
`define FBSA_STAT_CRY_BIT 4
`define FBSA_STAT_OVF_BIT 5
`define FBSA_STAT_NEG_BIT 6
`define FBSA_STAT_ZER_BIT 7
`define FBSA_STAT_PHS_BIT 8

`define FBSA_RESP_OKAY    2'h0
`define FBSA_RESP_SLVERR  2'h2

`define FBSA_WORD_RST     4'h0

`endif

// ---- inc/fbsa_pkg.sv ----
/*
  types of the four-bit slice: instruction field codes, phase and state records.
  assumes fbsa_defines.svh is on the include path.
*/
package fbsa_pkg;

  typedef enum logic [2:0] {
    SRC_AQ = 3'b000, SRC_AB = 3'b001, SRC_ZQ = 3'b010, SRC_ZB = 3'b011,
    SRC_ZA = 3'b100, SRC_DA = 3'b101, SRC_DQ = 3'b110, SRC_DZ = 3'b111
  } fbsa_src_t;

  typedef enum logic [2:0] {
    FN_ADD  = 3'b000, FN_SUBR = 3'b001, FN_SUBS  = 3'b010, FN_OR    = 3'b011,
    FN_AND  = 3'b100, FN_NOTRS = 3'b101, FN_XOR  = 3'b110, FN_XNOR  = 3'b111
  } fbsa_func_t;

  typedef enum logic [2:0] {
    DST_AUX  = 3'b000, DST_NOP  = 3'b001, DST_FILEA = 3'b010, DST_FILEF = 3'b011,
    DST_DNQ  = 3'b100, DST_DN   = 3'b101, DST_UPQ   = 3'b110, DST_UP    = 3'b111
  } fbsa_dest_t;

  typedef enum logic {
    PH_LOW  = 1'b0,
    PH_HIGH = 1'b1
  } fbsa_phase_t;

  typedef struct packed {
    fbsa_phase_t      phase;
    logic [15:0][3:0] file;
    logic [3:0]       aux;
    logic [3:0]       latA;
    logic [3:0]       latB;
    logic [3:0]       latD;
    logic [3:0]       addrB;
    logic [8:0]       instr;
    logic             cin;
    logic [3:0]       resultOut;
    logic             resultOutOeN;
    logic             fileMsbOut;
    logic             fileMsbOeN;
    logic             fileLsbOut;
    logic             fileLsbOeN;
    logic             auxMsbOut;
    logic             auxMsbOeN;
    logic             auxLsbOut;
    logic             auxLsbOeN;
    logic             carryOut;
    logic             ovf;
    logic             sign;
    logic             zero;
    logic             genN;
    logic             propN;
  } fbsa_state_t;

  typedef struct packed {
    logic        awHeld;
    logic [3:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [31:0] ctrl;
  } fbsa_axil_state_t;

endpackage

// ---- logic/fbsa_alu.sv ----
/*
  operand selection and eight-function alu of the slice, purely combinational.
  assumes its operands come from the slice's port latches and auxiliary register.
*/
`timescale 1ns/1ps
`default_nettype none
module fbsa_alu
  import fbsa_pkg::*;
(
  input  wire logic [3:0] latA,
  input  wire logic [3:0] latB,
  input  wire logic [3:0] aux,
  input  wire logic [3:0] latD,
  input  wire logic [2:0] src,
  input  wire logic [2:0] func,
  input  wire logic       cin,
  output logic      [3:0] opR,
  output logic      [3:0] opS,
  output logic      [3:0] f,
  output logic            carry,
  output logic            ovf,
  output logic            genN,
  output logic            propN
);
  logic [3:0] r;
  logic [3:0] s;
  logic [4:0] sum;
  logic [3:0] low3;
  logic [3:0] g;
  logic [3:0] p;

  always_comb begin
    unique case (fbsa_src_t'(src))
      SRC_AQ: begin opR = latA; opS = aux;  end
      SRC_AB: begin opR = latA; opS = latB; end
      SRC_ZQ: begin opR = 4'h0; opS = aux;  end
      SRC_ZB: begin opR = 4'h0; opS = latB; end
      SRC_ZA: begin opR = 4'h0; opS = latA; end
      SRC_DA: begin opR = latD; opS = latA; end
      SRC_DQ: begin opR = latD; opS = aux;  end
      SRC_DZ: begin opR = latD; opS = 4'h0; end
    endcase
  end

  // subtraction is addition of the one's complement; carry-in supplies the +1
  always_comb begin
    r = (fbsa_func_t'(func) == FN_SUBR) ? ~opR : opR;
    s = (fbsa_func_t'(func) == FN_SUBS) ? ~opS : opS;
    sum = {1'b0, r} + {1'b0, s} + {4'h0, cin};
    low3 = {1'b0, r[2:0]} + {1'b0, s[2:0]} + {3'h0, cin};
    g = r & s;
    p = r | s;
    genN = ~(g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (p[3] & p[2] & p[1] & g[0]));
    propN = ~(&p);
    carry = 1'b0;
    ovf = 1'b0;
    unique case (fbsa_func_t'(func))
      FN_ADD, FN_SUBR, FN_SUBS: begin
        f = sum[3:0];
        carry = sum[4];
        ovf = sum[4] ^ low3[3];
      end
      FN_OR:    f = opR | opS;
      FN_AND:   f = opR & opS;
      FN_NOTRS: f = ~opR & opS;
      FN_XOR:   f = opR ^ opS;
      FN_XNOR:  f = ~(opR ^ opS);
    endcase
  end
endmodule
`default_nettype wire

// ---- logic/fbsa_axil.sv ----
/*
  axi4-lite slave with a control word and a read-only status word.
  assumes a single-clock master that keeps at most one write and one read open.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fbsa_defines.svh"
module fbsa_axil
  import fbsa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] statusWord,
  output logic             runEnable
);
  fbsa_axil_state_t st_q;
  fbsa_axil_state_t st_d;

  // ready is high while the holding slot is free and no response is pending, so it never depends on valid
  assign awready = ~st_q.awHeld & ~st_q.bValid;
  assign wready = ~st_q.wHeld & ~st_q.bValid;
  assign arready = ~st_q.rValid;
  assign bvalid = st_q.bValid;
  assign bresp = st_q.bResp;
  assign rvalid = st_q.rValid;
  assign rdata = st_q.rData;
  assign rresp = st_q.rResp;
  assign runEnable = st_q.ctrl[`FBSA_CTRL_RUN_BIT];

  always_comb begin
    st_d = st_q;
    if (awvalid && awready) begin
      st_d.awHeld = 1'b1;
      // anything outside the sixteen-byte window folds onto an unmapped offset
      st_d.awAddr = (awaddr[31:4] == 28'h0) ? awaddr[3:0] : 4'hf;
    end
    if (wvalid && wready) begin
      st_d.wHeld = 1'b1;
      st_d.wData = wdata;
      st_d.wStrb = wstrb;
    end
    if (st_q.awHeld && st_q.wHeld) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp = `FBSA_RESP_OKAY;
      if (st_q.awAddr == `FBSA_CTRL_OFS) begin
        for (int i = 0; i < 4; i++) begin
          if (st_q.wStrb[i]) begin
            st_d.ctrl[i*8 +: 8] = st_q.wData[i*8 +: 8];
          end
        end
        st_d.ctrl[31:1] = 31'h0;
      end else if (st_q.awAddr != `FBSA_STAT_OFS) begin
        st_d.bResp = `FBSA_RESP_SLVERR;
      end
    end
    if (st_q.bValid && bready) begin
      st_d.bValid = 1'b0;
    end
    if (st_q.rValid && rready) begin
      st_d.rValid = 1'b0;
    end
    if (arvalid && arready) begin
      st_d.rValid = 1'b1;
      st_d.rResp = `FBSA_RESP_OKAY;
      if (araddr[3:0] == `FBSA_CTRL_OFS && araddr[31:4] == 28'h0) begin
        st_d.rData = st_q.ctrl;
      end else if (araddr[3:0] == `FBSA_STAT_OFS && araddr[31:4] == 28'h0) begin
        st_d.rData = statusWord;
      end else begin
        st_d.rData = 32'h0;
        st_d.rResp = `FBSA_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{awHeld: 1'b0, awAddr: 4'h0, wHeld: 1'b0, wData: 32'h0, wStrb: 4'h0,
                bValid: 1'b0, bResp: 2'h0, rValid: 1'b0, rData: 32'h0, rResp: 2'h0,
                ctrl: `FBSA_CTRL_RST};
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// ---- logic/fbsa_slice.sv ----
/*
  four-bit datapath slice: register file, port latches, alu, auxiliary shifter,
  shift-line drivers and status, with an axi4-lite control and status window.
  assumes the microinstruction, operands and shift inputs come from logic on clk.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
// How it works
// - sixteen four-bit words, two read ports usable together
// - first port select picks word shown on first port latch
// - second port select picks second port word and the write-back word
// - instruction bits 0-2 source, 3-5 function, 6-8 destination
// - external operand lines feed the alu when source code picks them
// - result lines show alu result or first port latch per destination
// - result lines driven only while drive enable low, else released
// - file written in low phase, port latches loaded from the updated file in the same low phase
// - auxiliary register captures in low phase, holds its value through high
// - shift lines change direction and drivers by destination code
// - eight alu operations on two four-bit operands
// - carry and overflow reported for add and both subtracts, negative and zero for every operation
// - slices chain in four-bit steps via carry or generate/propagate
// - source code selects one of eight operand pairs
// - function code selects add, two subtracts and five logic functions
// - destination loads aux and/or file unshifted, halved or doubled
// - overflow is carry into msb xor carry out; zero when result zero
`timescale 1ns/1ps
`default_nettype none
`include "fbsa_defines.svh"
module fbsa_slice
  import fbsa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  firstPortSelect,
  input  wire logic [3:0]  secondPortSelect,
  input  wire logic [8:0]  microinstructionBits,
  input  wire logic [3:0]  externalOperandIn,
  input  wire logic        carryInPin,
  input  wire logic        yDriveEnableN,
  output logic      [3:0]  resultOut,
  output logic             resultOutOeN,
  input  wire logic        fileMsbShiftLineIn,
  output logic             fileMsbShiftLineOut,
  output logic             fileMsbShiftLineOeN,
  input  wire logic        fileLsbShiftLineIn,
  output logic             fileLsbShiftLineOut,
  output logic             fileLsbShiftLineOeN,
  input  wire logic        auxMsbShiftLineIn,
  output logic             auxMsbShiftLineOut,
  output logic             auxMsbShiftLineOeN,
  input  wire logic        auxLsbShiftLineIn,
  output logic             auxLsbShiftLineOut,
  output logic             auxLsbShiftLineOeN,
  output logic             carryOutPin,
  output logic             overflowFlag,
  output logic             signBitOut,
  output logic             zeroResultFlag,
  output logic             carryGenerateN,
  output logic             carryPropagateN,
  output logic             sliceClock,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  fbsa_state_t st_q;
  fbsa_state_t st_d;
  logic        runEnable;
  logic [31:0] statusWord;
  fbsa_src_t   src;
  fbsa_func_t  func;
  fbsa_dest_t  dest;
  logic [3:0]  aluR;
  logic [3:0]  aluS;
  logic [3:0]  aluF;
  logic        aluCarry;
  logic        aluOvf;
  logic        aluGenN;
  logic        aluPropN;
  logic        shiftsQuiet;

  assign src = fbsa_src_t'(st_q.instr[`FBSA_SRC_LSB +: 3]);
  assign func = fbsa_func_t'(st_q.instr[`FBSA_FUNC_LSB +: 3]);
  assign dest = fbsa_dest_t'(st_q.instr[`FBSA_DEST_LSB +: 3]);

  // the alu sees only latched values, so its result is stable for the whole cycle
  fbsa_alu u_alu (
    .latA  (st_q.latA),
    .latB  (st_q.latB),
    .aux   (st_q.aux),
    .latD  (st_q.latD),
    .src   (st_q.instr[`FBSA_SRC_LSB +: 3]),
    .func  (st_q.instr[`FBSA_FUNC_LSB +: 3]),
    .cin   (st_q.cin),
    .opR   (aluR),
    .opS   (aluS),
    .f     (aluF),
    .carry (aluCarry),
    .ovf   (aluOvf),
    .genN  (aluGenN),
    .propN (aluPropN)
  );

  always_comb begin
    statusWord = 32'h0;
    statusWord[`FBSA_STAT_AUX_LSB +: 4] = st_q.aux;
    statusWord[`FBSA_STAT_CRY_BIT] = st_q.carryOut;
    statusWord[`FBSA_STAT_OVF_BIT] = st_q.ovf;
    statusWord[`FBSA_STAT_NEG_BIT] = st_q.sign;
    statusWord[`FBSA_STAT_ZER_BIT] = st_q.zero;
    statusWord[`FBSA_STAT_PHS_BIT] = st_q.phase;
  end

  fbsa_axil u_axil (
    .clk        (clk),
    .rstn       (rstn),
    .awaddr     (awaddr),
    .awvalid    (awvalid),
    .awready    (awready),
    .wdata      (wdata),
    .wstrb      (wstrb),
    .wvalid     (wvalid),
    .wready     (wready),
    .bresp      (bresp),
    .bvalid     (bvalid),
    .bready     (bready),
    .araddr     (araddr),
    .arvalid    (arvalid),
    .arready    (arready),
    .rdata      (rdata),
    .rresp      (rresp),
    .rvalid     (rvalid),
    .rready     (rready),
    .statusWord (statusWord),
    .runEnable  (runEnable)
  );

  assign shiftsQuiet = ~st_q.instr[`FBSA_DEST_LSB + 4'd2];

  always_comb begin
    st_d = st_q;
    st_d.resultOutOeN = yDriveEnableN;
    if (st_q.phase == PH_HIGH) begin
      // end of high phase: present results and set shift-line drivers
      st_d.phase = PH_LOW;
      st_d.resultOut = (dest == DST_FILEA) ? st_q.latA : aluF;
      st_d.carryOut = aluCarry;
      st_d.ovf = aluOvf;
      st_d.sign = aluF[3];
      st_d.zero = (aluF == 4'h0);
      st_d.genN = aluGenN;
      st_d.propN = aluPropN;
      st_d.fileMsbOeN = 1'b1;
      st_d.fileLsbOeN = 1'b1;
      st_d.auxMsbOeN = 1'b1;
      st_d.auxLsbOeN = 1'b1;
      unique case (dest)
        DST_AUX, DST_NOP, DST_FILEA, DST_FILEF: begin
        end
        DST_DNQ: begin
          st_d.fileLsbOeN = 1'b0;
          st_d.auxLsbOeN = 1'b0;
        end
        DST_DN: begin
          st_d.fileLsbOeN = 1'b0;
          st_d.auxLsbOeN = 1'b0;
        end
        DST_UPQ, DST_UP: begin
          st_d.fileMsbOeN = 1'b0;
          st_d.auxMsbOeN = 1'b0;
        end
      endcase
      st_d.fileLsbOut = aluF[0];
      st_d.fileMsbOut = aluF[3];
      st_d.auxLsbOut = st_q.aux[0];
      st_d.auxMsbOut = st_q.aux[3];
    end else begin
      // end of low phase: write back, then load latches from the updated file
      st_d.phase = PH_HIGH;
      if (runEnable) begin
        unique case (dest)
          DST_AUX: st_d.aux = aluF;
          DST_NOP: begin
          end
          DST_FILEA, DST_FILEF: st_d.file[st_q.addrB] = aluF;
          DST_DNQ: begin
            st_d.file[st_q.addrB] = {fileMsbShiftLineIn, aluF[3:1]};
            st_d.aux = {auxMsbShiftLineIn, st_q.aux[3:1]};
          end
          DST_DN: st_d.file[st_q.addrB] = {fileMsbShiftLineIn, aluF[3:1]};
          DST_UPQ: begin
            st_d.file[st_q.addrB] = {aluF[2:0], fileLsbShiftLineIn};
            st_d.aux = {st_q.aux[2:0], auxLsbShiftLineIn};
          end
          DST_UP: st_d.file[st_q.addrB] = {aluF[2:0], fileLsbShiftLineIn};
        endcase
      end
      // reading the post-write file avoids a stale word after back-to-back use
      st_d.latA = st_d.file[firstPortSelect];
      st_d.latB = st_d.file[secondPortSelect];
      st_d.addrB = secondPortSelect;
      st_d.latD = externalOperandIn;
      st_d.instr = microinstructionBits;
      st_d.cin = carryInPin;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.resultOutOeN <= 1'b1;
      st_q.fileMsbOeN <= 1'b1;
      st_q.fileLsbOeN <= 1'b1;
      st_q.auxMsbOeN <= 1'b1;
      st_q.auxLsbOeN <= 1'b1;
      st_q.genN <= 1'b1;
      st_q.propN <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign resultOut = st_q.resultOut;
  assign resultOutOeN = st_q.resultOutOeN;
  assign fileMsbShiftLineOut = st_q.fileMsbOut;
  assign fileMsbShiftLineOeN = st_q.fileMsbOeN;
  assign fileLsbShiftLineOut = st_q.fileLsbOut;
  assign fileLsbShiftLineOeN = st_q.fileLsbOeN;
  assign auxMsbShiftLineOut = st_q.auxMsbOut;
  assign auxMsbShiftLineOeN = st_q.auxMsbOeN;
  assign auxLsbShiftLineOut = st_q.auxLsbOut;
  assign auxLsbShiftLineOeN = st_q.auxLsbOeN;
  assign carryOutPin = st_q.carryOut;
  assign overflowFlag = st_q.ovf;
  assign signBitOut = st_q.sign;
  assign zeroResultFlag = st_q.zero;
  assign carryGenerateN = st_q.genN;
  assign carryPropagateN = st_q.propN;
  assign sliceClock = st_q.phase;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_high;
    st_q.phase == PH_HIGH;
  endsequence

  sequence s_lowWrite;
    st_q.phase == PH_LOW && runEnable;
  endsequence

  sequence s_lowHold;
    st_q.phase == PH_LOW && !runEnable;
  endsequence

  a_phase_alternates: assert property (
    st_q.phase == PH_HIGH |=> st_q.phase == PH_LOW ##1 st_q.phase == PH_HIGH
  ) else $error("slice phase did not alternate");

  a_latch_holds_low: assert property (
    s_high |=> $stable(st_q.latA) && $stable(st_q.latB)
  ) else $error("port latches changed in low phase");

  a_file_write: assert property (
    s_lowWrite ##0 (dest == DST_FILEF) |=> st_q.file[$past(st_q.addrB)] == $past(aluF)
  ) else $error("file word not written with alu result");

  a_y_source: assert property (
    s_high ##0 (dest == DST_FILEA) |=> resultOut == $past(st_q.latA)
  ) else $error("result lines did not show first port latch");

  a_y_drive: assert property (
    rstn |=> resultOutOeN == $past(yDriveEnableN)
  ) else $error("result drivers not following drive enable");

  a_zero_flag: assert property (
    s_high |=> zeroResultFlag == ($past(aluF) == 4'h0) && signBitOut == $past(aluF[3])
  ) else $error("zero or sign flag wrong");

  a_ovf_add: assert property (
    s_high ##0 (func == FN_ADD) |=>
      overflowFlag == ($past(aluR[3]) == $past(aluS[3]) && $past(aluF[3]) != $past(aluR[3]))
  ) else $error("overflow flag wrong for add");

  a_shift_quiet: assert property (
    s_high ##0 shiftsQuiet |=> fileMsbShiftLineOeN && fileLsbShiftLineOeN
                               && auxMsbShiftLineOeN && auxLsbShiftLineOeN
  ) else $error("shift line driven for non-shift destination");

  a_aux_down: assert property (
    s_lowWrite ##0 (dest == DST_DNQ) |=>
      st_q.aux == {$past(auxMsbShiftLineIn), $past(st_q.aux[3:1])}
  ) else $error("auxiliary register did not shift down");

  a_ext_operand: assert property (
    s_high ##0 (src == SRC_DZ && func == FN_OR && dest != DST_FILEA) |=>
      resultOut == $past(st_q.latD)
  ) else $error("external operand not passed through");

  a_aux_up: assert property (
    s_lowWrite ##0 (dest == DST_UPQ) |=>
      st_q.aux == {$past(st_q.aux[2:0]), $past(auxLsbShiftLineIn)}
  ) else $error("auxiliary register did not shift up");

  a_file_down: assert property (
    s_lowWrite ##0 (dest == DST_DN) |=>
      st_q.file[$past(st_q.addrB)] == {$past(fileMsbShiftLineIn), $past(aluF[3:1])}
  ) else $error("file word not halved");

  a_file_up: assert property (
    s_lowWrite ##0 (dest == DST_UP) |=>
      st_q.file[$past(st_q.addrB)] == {$past(aluF[2:0]), $past(fileLsbShiftLineIn)}
  ) else $error("file word not doubled");

  a_shift_drive: assert property (
    s_high ##0 (dest == DST_UPQ || dest == DST_UP) |=>
      !fileMsbShiftLineOeN && !auxMsbShiftLineOeN && fileMsbShiftLineOut == $past(aluF[3])
  ) else $error("msb shift lines not driven for up shift");

  // logic functions report no carry, so a lookahead user must not rely on carry-out there
  a_logic_carry: assert property (
    s_high ##0 !(func inside {FN_ADD, FN_SUBR, FN_SUBS}) |=> !carryOutPin && !overflowFlag
  ) else $error("carry or overflow set by logic function");

  a_run_off_hold: assert property (
    s_lowHold |=> $stable(st_q.file) && $stable(st_q.aux)
  ) else $error("file or auxiliary register written with run bit off");

endmodule
`default_nettype wire

// ---- dv/fbsa_nbr_model.sv ----
/*
  neighbour slices on the four shift lines: resolves each two-way line.
  assumes the bench sets what the neighbours drive on lines the slice releases.
*/
`timescale 1ns/1ps
`default_nettype none
module fbsa_nbr_model (
  input  wire logic [3:0] slOut,
  input  wire logic [3:0] slOeN,
  input  wire logic [3:0] nbDrive,
  output logic      [3:0] lineIn
);
  // neighbours only drive lines the slice has released, so no contention is modelled
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lineIn[i] = slOeN[i] ? nbDrive[i] : slOut[i];
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
/*
  self-checking bench of the four-bit slice: instruction steps and axi4-lite accesses.
  assumes a 40 MHz clock and the neighbour model on the shift lines.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rstn, ci, yEnN, awvalid, wvalid, bready, arvalid, rready, run;
  logic [3:0]  aSel, bSel, dIn, wstrb, nb, q;
  logic [8:0]  mi;
  logic [31:0] awaddr, wdata, araddr, rd;
  logic [3:0]  sh [16];
  wire  [3:0]  y, slOut, slOeN, lineIn;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         cOut, ovf, sgn, zf, gN, pN, yOeN, ph, awready, wready, bvalid, arready, rvalid;
  int          fails, cmp_count;

  fbsa_slice i_dut (.clk(clk), .rstn(rstn), .firstPortSelect(aSel), .secondPortSelect(bSel),
    .microinstructionBits(mi), .externalOperandIn(dIn), .carryInPin(ci),
    .yDriveEnableN(yEnN), .resultOut(y), .resultOutOeN(yOeN),
    .fileMsbShiftLineIn(lineIn[3]), .fileMsbShiftLineOut(slOut[3]),
    .fileMsbShiftLineOeN(slOeN[3]), .fileLsbShiftLineIn(lineIn[2]),
    .fileLsbShiftLineOut(slOut[2]), .fileLsbShiftLineOeN(slOeN[2]),
    .auxMsbShiftLineIn(lineIn[1]), .auxMsbShiftLineOut(slOut[1]),
    .auxMsbShiftLineOeN(slOeN[1]), .auxLsbShiftLineIn(lineIn[0]),
    .auxLsbShiftLineOut(slOut[0]), .auxLsbShiftLineOeN(slOeN[0]),
    .carryOutPin(cOut), .overflowFlag(ovf), .signBitOut(sgn), .zeroResultFlag(zf),
    .carryGenerateN(gN), .carryPropagateN(pN), .sliceClock(ph),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  fbsa_nbr_model i_nbr (.slOut(slOut), .slOeN(slOeN), .nbDrive(nb), .lineIn(lineIn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // reference alu: {f, carry, overflow, sign, zero, generateN, propagateN}
  function automatic logic [9:0] alu(input logic [2:0] fn, input logic [3:0] r,
                                     input logic [3:0] s, input logic c);
    logic [3:0] x, v, f, lo;
    logic [4:0] t, g;
    x = (fn == 3'd1) ? ~r : r;
    v = (fn == 3'd2) ? ~s : s;
    t = {1'b0, x} + {1'b0, v} + {4'h0, c};
    g = {1'b0, x} + {1'b0, v};
    lo = {1'b0, x[2:0]} + {1'b0, v[2:0]} + {3'h0, c};
    case (fn)
      3'd3: f = r | s;
      3'd4: f = r & s;
      3'd5: f = ~r & s;
      3'd6: f = r ^ s;
      3'd7: f = ~(r ^ s);
      default: f = t[3:0];
    endcase
    return {f, (fn < 3'd3) & t[4], (fn < 3'd3) & (t[4] ^ lo[3]), f[3], f == 4'h0,
            ~g[4], ~&(x | v)};
  endfunction

  // one instruction, then a no-write step so a held shift never repeats
  task automatic op(input logic [3:0] a, input logic [3:0] b, input logic [8:0] i,
                    input logic [3:0] d, input logic c);
    logic [3:0] r, s;
    logic [9:0] e;
    logic [2:0] dst;
    r = (i[2:0] < 3'd5) ? ((i[2:0] < 3'd2) ? sh[a] : 4'h0) : d;
    case (i[2:0])
      3'd1, 3'd3: s = sh[b];
      3'd4, 3'd5: s = sh[a];
      3'd7: s = 4'h0;
      default: s = q;
    endcase
    e = alu(i[5:3], r, s, c);
    dst = i[8:6];
    while (ph !== 1'b1) @(posedge clk);
    aSel <= a;
    bSel <= b;
    mi <= i;
    dIn <= d;
    ci <= c;
    repeat (2) @(posedge clk);
    mi <= {3'd1, i[5:0]};
    @(posedge clk);
    chk({y, cOut, ovf, sgn, zf}, {(dst == 3'd2) ? sh[a] : e[9:6], e[5:2]});
    if (i[5:3] == 3'd0) chk({gN, pN}, e[1:0]);
    chk({yOeN, slOeN}, {yEnN, (dst < 3'd4) ? 4'hf : dst[1] ? 4'h5 : 4'ha});
    chk(slOut & ~slOeN, {e[9], e[6], q[3], q[0]} & ~slOeN);
    if (run) begin
      case (dst)
        3'd0: q = e[9:6];
        3'd2, 3'd3: sh[b] = e[9:6];
        3'd4, 3'd5: sh[b] = {nb[3], e[9:7]};
        3'd6, 3'd7: sh[b] = {e[8:6], nb[2]};
        default: ;
      endcase
      if (dst == 3'd4) q = {nb[1], q[3:1]};
      if (dst == 3'd6) q = {q[2:0], nb[0]};
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, r);
    @(posedge clk);
  endtask

  task automatic rdw(input logic [31:0] a, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    chk(rresp, r);
    @(posedge clk);
  endtask

  initial begin
    {rstn, ci, yEnN, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {aSel, bSel, dIn, q, awaddr, wdata, araddr} = '0;
    mi = 9'h040;
    nb = 4'h9;
    wstrb = 4'hf;
    run = 1'b1;
    foreach (sh[k]) sh[k] = 4'h0;
    repeat (20) @(posedge clk);
    chk({yOeN, slOeN, gN, pN, ph, awready, wready, arready}, 11'h7f7);
    rstn <= 1'b1;
    for (int k = 0; k < 16; k++) op(4'h0, k[3:0], 9'h0df, ~k[3:0], 1'b0);
    for (int k = 0; k < 16; k++) op(k[3:0], 4'(15 - k), 9'h041, 4'h0, k[0]);
    for (int k = 0; k < 64; k++) op(4'h3, 4'hc, {3'd0, 6'(k)}, 4'(k ^ 6), k[1]);
    for (int k = 0; k < 32; k++) begin
      nb <= 4'(k * 3);
      op(k[3:0], 4'(k + 5), {k[2:0], 6'o25}, 4'(k), k[3]);
    end
    for (int k = 0; k < 16; k++) op(k[3:0], 4'h0, 9'h05c, 4'h0, 1'b0);
    yEnN <= 1'b1;
    op(4'h1, 4'h2, 9'h041, 4'h0, 1'b1);
    yEnN <= 1'b0;
    rdw(32'h4, 2'h0);
    chk(rd[3:0], q);
    rdw(32'h0, 2'h0);
    chk(rd, 32'h1);
    // run bit off: the file must keep its word
    wr(32'h0, 32'h0, 2'h0);
    run = 1'b0;
    op(4'h0, 4'h2, 9'h0df, 4'ha, 1'b0);
    op(4'h2, 4'h2, 9'h05c, 4'h0, 1'b0);
    wr(32'h0, 32'h1, 2'h0);
    run = 1'b1;
    wr(32'h4, 32'hff, 2'h0);
    rdw(32'h10, 2'h2);
    chk(rd, 32'h0);
    wr(32'h10, 32'h0, 2'h2);
    finish_test();
  end

  // whole run needs roughly 640 clocks
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
